/* File: design/frr_pkg.sv */
package frr_pkg;
  // Clock and time base
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 7;

  // Register byte offsets
  localparam logic [7:0] OFS_RESP = 8'h00;
  localparam logic [7:0] OFS_UNIT = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Response byte fields
  localparam int RESP_ACT_HI = 7;
  localparam int RESP_ACT_LO = 6;
  localparam int RESP_RETRY_HI = 5;
  localparam int RESP_RETRY_LO = 3;
  localparam int RESP_DLY_HI = 2;
  localparam int RESP_DLY_LO = 0;

  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_CONT = 2'h1;
  localparam logic [1:0] ACT_SHUT = 2'h2;
  localparam logic [1:0] ACT_HOLD = 2'h3;

  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_CONT = 3'h7;

  // Control bits
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_OPER_BIT = 1;

  // Status bits
  localparam int ST_LATCH_BIT = 0;
  localparam int ST_OUT_BIT = 1;
  localparam int ST_RETRY_BIT = 2;
  localparam int ST_FAULT_BIT = 3;
  localparam int ST_REM_LO = 4;
  localparam int ST_REM_HI = 6;

  // Interrupt events
  localparam int IRQ_W = 3;
  localparam int EV_FAULT = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_OK = 2;

  // Reset values
  localparam logic [7:0] RESP_RST = 8'h90;
  localparam logic [15:0] UNIT_RST = 16'h0064;
  localparam logic OPER_RST = 1'b1;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_RUN = 7'h02,
    ST_CONT = 7'h04,
    ST_WAIT = 7'h08,
    ST_TRY = 7'h10,
    ST_LATCH = 7'h20,
    ST_HOLD = 7'h40
  } frr_state_type;

  function automatic logic [7:0] frr_pow2(input logic [2:0] code);
    frr_pow2 = 8'h01 << code;
  endfunction : frr_pow2

  function automatic frr_state_type frr_shut_state(input logic [2:0] retry);
    frr_shut_state = (retry == RETRY_NONE) ? ST_LATCH : ST_WAIT;
  endfunction : frr_shut_state
endpackage : frr_pkg

/* File: design/frr_tmr_if.sv */
`timescale 1ns/1ns
interface frr_tmr_if;
  logic start;
  logic [2:0] code;
  logic [15:0] unit;
  logic done;
  modport ctl (output start, output code, output unit, input done);
  modport tmr (input start, input code, input unit, output done);
endinterface : frr_tmr_if

/* File: design/frr_timer.sv */
`timescale 1ns/1ns
module frr_timer import frr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  frr_tmr_if.tmr tmr
);
  logic [TICK_W-1:0] pre_r;
  logic tick;
  logic run_r;
  logic done_r;
  logic [7:0] units_r;
  logic [15:0] us_r;
  logic [15:0] unit_len;

  // A zero unit would never expire, so it counts as one
  assign unit_len = (tmr.unit == 16'h0000) ? 16'h0001 : tmr.unit;
  assign tick = (pre_r == TICK_W'(TICK_CYC - 1));
  assign tmr.done = done_r;

  // Prescaler restarts with each timing so the first unit is full length
  always_ff @(posedge clk_i) begin
    if (rst_i || tmr.start || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
      done_r <= 1'b0;
      units_r <= 8'h00;
      us_r <= 16'h0000;
    end else if (tmr.start) begin
      run_r <= 1'b1;
      done_r <= 1'b0;
      units_r <= frr_pow2(tmr.code);
      us_r <= unit_len;
    end else if (run_r && tick) begin
      if (us_r <= 16'h0001) begin
        if (units_r <= 8'h01) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          units_r <= units_r - 8'h01;
          us_r <= unit_len;
        end
      end else begin
        us_r <= us_r - 16'h0001;
      end
    end
  end
endmodule : frr_timer

/* File: design/frr_top.sv */
`timescale 1ns/1ns
// Behaviour
// - Retry count comes from response bits 5:3
// - Retry 000: no restart, latch off
// - Retry 111: restart forever
// - Retry 1..6: that many, then latch off
// - Attempt starts spaced by delay times unit
// - Delay code gives power-of-two units
// - Bits 7:6 pick ignore/continue/shutdown/hold
// - Clear, command, off-on cycle, bias loss unlatch
module frr_top import frr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fault_i,
  input wire logic ctrl_pin_i,
  input wire logic bias_ok_i,
  output logic out_en_o,
  output logic irq_o
);
  logic [1:0] fault_sync_r;
  logic [1:0] ctrl_sync_r;
  logic [1:0] bias_sync_r;
  logic fault_s;
  logic cmd_on;
  logic cmd_on_r;

  logic [7:0] resp_r;
  logic [15:0] unit_r;
  logic oper_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_mask_nxt;
  logic ack_r;
  logic [31:0] dat_r;

  logic bus_req;
  logic wr;
  logic rd;
  logic clr_cmd;
  logic clr_w1c;
  logic fault_clear;

  frr_state_type state_r;
  frr_state_type state_nxt;
  logic [2:0] rem_r;
  logic [2:0] rem_nxt;
  logic tmr_start;
  logic ev_fault;
  logic ev_latch;
  logic ev_ok;
  logic [1:0] action;
  logic [2:0] retry;
  logic cont;
  logic [IRQ_W-1:0] ev_vec;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] status_word;

  frr_tmr_if tmr_bus ();

  frr_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tmr(tmr_bus)
  );

  // Pins cross in through two flops each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_sync_r <= 2'h0;
      ctrl_sync_r <= 2'h0;
      bias_sync_r <= 2'h0;
    end else begin
      fault_sync_r <= {fault_sync_r[0], fault_i};
      ctrl_sync_r <= {ctrl_sync_r[0], ctrl_pin_i};
      bias_sync_r <= {bias_sync_r[0], bias_ok_i};
    end
  end

  assign fault_s = fault_sync_r[1];
  assign cmd_on = ctrl_sync_r[1] && oper_r && bias_sync_r[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_on_r <= 1'b0;
    end else begin
      cmd_on_r <= cmd_on;
    end
  end

  // Response byte decode
  assign action = resp_r[RESP_ACT_HI:RESP_ACT_LO];
  assign retry = resp_r[RESP_RETRY_HI:RESP_RETRY_LO];
  assign cont = (retry == RETRY_CONT);

  // Bus decode; effect lands on the edge that raises ack
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = bus_req && wb_we_i;
  assign rd = bus_req && !wb_we_i;
  assign clr_cmd = wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_CLR_BIT];
  assign clr_w1c = wr && (wb_adr_i == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_LATCH_BIT];
  // Power-up after an off period also counts as the on edge
  assign fault_clear = clr_cmd || clr_w1c || (cmd_on && !cmd_on_r);

  assign tmr_bus.start = tmr_start;
  assign tmr_bus.code = resp_r[RESP_DLY_HI:RESP_DLY_LO];
  assign tmr_bus.unit = unit_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_r <= RESP_RST;
    end else if (wr && (wb_adr_i == OFS_RESP) && wb_sel_i[0]) begin
      resp_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_r <= UNIT_RST;
    end else if (wr && (wb_adr_i == OFS_UNIT)) begin
      if (wb_sel_i[0]) begin
        unit_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        unit_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oper_r <= OPER_RST;
    end else if (wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]) begin
      oper_r <= wb_dat_i[CTRL_OPER_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= MASK_RST;
    end else if (wr && (wb_adr_i == OFS_IRQ_MASK) && wb_sel_i[0]) begin
      irq_mask_r <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  assign ev_vec = {ev_ok, ev_latch, ev_fault};
  assign irq_clr = (wr && (wb_adr_i == OFS_IRQ_STAT) && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;
  // Mask write reaches irq on the same edge as the register
  assign irq_mask_nxt = (wr && (wb_adr_i == OFS_IRQ_MASK) && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : irq_mask_r;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | ev_vec;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_o <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_LATCH_BIT] = (state_r == ST_LATCH);
    status_word[ST_OUT_BIT] = out_en_o;
    status_word[ST_RETRY_BIT] = (state_r == ST_WAIT) || (state_r == ST_TRY);
    status_word[ST_FAULT_BIT] = fault_s;
    status_word[ST_REM_HI:ST_REM_LO] = rem_r;
  end

  // Unmapped reads answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i)
        OFS_RESP: dat_r <= {24'h00_0000, resp_r};
        OFS_UNIT: dat_r <= {16'h0000, unit_r};
        OFS_CTRL: dat_r <= {30'h0000_0000, oper_r, 1'b0};
        OFS_STATUS: dat_r <= status_word;
        OFS_IRQ_STAT: dat_r <= {29'h0000_0000, irq_stat_r};
        OFS_IRQ_MASK: dat_r <= {29'h0000_0000, irq_mask_r};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_comb begin
    state_nxt = state_r;
    rem_nxt = rem_r;
    tmr_start = 1'b0;
    ev_fault = 1'b0;
    ev_latch = 1'b0;
    ev_ok = 1'b0;
    if (!cmd_on) begin
      // Commanded off or bias lost
      state_nxt = ST_OFF;
      rem_nxt = retry;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_nxt = ST_RUN;
          rem_nxt = retry;
        end
        ST_RUN: begin
          if (fault_s) begin
            ev_fault = 1'b1;
            case (action)
              ACT_IGNORE: state_nxt = ST_RUN;
              ACT_CONT: begin
                state_nxt = ST_CONT;
                tmr_start = 1'b1;
              end
              ACT_SHUT: begin
                state_nxt = frr_shut_state(retry);
                tmr_start = (retry != RETRY_NONE);
                ev_latch = (retry == RETRY_NONE);
                rem_nxt = retry;
              end
              ACT_HOLD: state_nxt = ST_HOLD;
              default: state_nxt = ST_RUN;
            endcase
          end
        end
        ST_CONT: begin
          // Output stays on for the delay, then retry setting applies if the fault persists, else back to run
          if (tmr_bus.done) begin
            if (fault_s) begin
              state_nxt = frr_shut_state(retry);
              tmr_start = (retry != RETRY_NONE);
              ev_latch = (retry == RETRY_NONE);
              rem_nxt = retry;
            end else begin
              state_nxt = ST_RUN;
            end
          end
        end
        ST_WAIT: begin
          // Timer runs from the start of the previous attempt
          if (tmr_bus.done) begin
            state_nxt = ST_TRY;
            tmr_start = 1'b1;
            if (!cont) begin
              rem_nxt = rem_r - 3'h1;
            end
          end
        end
        ST_TRY: begin
          if (fault_s) begin
            ev_fault = 1'b1;
            if (cont || (rem_r != 3'h0)) begin
              state_nxt = ST_WAIT;
            end else begin
              state_nxt = ST_LATCH;
              ev_latch = 1'b1;
            end
          end else if (tmr_bus.done) begin
            // Fault-free for one full delay counts as a good restart
            state_nxt = ST_RUN;
            ev_ok = 1'b1;
            rem_nxt = retry;
          end
        end
        ST_LATCH: begin
          if (fault_clear) begin
            state_nxt = ST_RUN;
            rem_nxt = retry;
          end
        end
        ST_HOLD: begin
          if (!fault_s) begin
            state_nxt = ST_RUN;
          end
        end
        default: state_nxt = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
      rem_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      rem_r <= rem_nxt;
    end
  end

  // Output enable follows the next state so it aligns with state_r
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_en_o <= 1'b0;
    end else begin
      out_en_o <= (state_nxt == ST_RUN) || (state_nxt == ST_CONT) || (state_nxt == ST_TRY);
    end
  end
endmodule : frr_top

/* File: testbench/frr_chk.sv */
`timescale 1ns/1ns
module frr_chk import frr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic fault_i,
  input wire logic ctrl_pin_i,
  input wire logic bias_ok_i,
  input wire logic out_en_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] resp_r;
  logic [15:0] unit_r;
  logic att_r;
  logic [31:0] low_r;
  logic wr;
  int dly;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  // Unit 0 acts as 1
  assign dly = (1 << resp_r[2:0]) * ((unit_r == 16'h0000) ? 1 : int'(unit_r)) * TICK_CYC;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_r <= RESP_RST;
      unit_r <= UNIT_RST;
    end else if (wr && wb_adr_i == OFS_RESP && wb_sel_i[0]) begin
      resp_r <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == OFS_UNIT) begin
      unit_r <= {wb_sel_i[1] ? wb_dat_i[15:8] : unit_r[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : unit_r[7:0]};
    end
  end
  // Any bus write may clear a latch, so no attempt follows
  always_ff @(posedge clk_i) begin
    if (rst_i || wr || !ctrl_pin_i || !bias_ok_i) begin
      att_r <= 1'h0;
    end else if ($fell(out_en_o) && resp_r[7:6] == ACT_SHUT && resp_r[5:3] != RETRY_NONE) begin
      att_r <= 1'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    low_r <= (rst_i || out_en_o) ? 32'h0000_0000 : low_r + 32'h0000_0001;
  end
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_idle;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_quiet;
    $fell(rst_i) |-> !wb_ack_o && !out_en_o && !irq_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs active after reset");
  property p_ignore;
    (ctrl_pin_i && bias_ok_i)[*4] ##0 (resp_r[7:6] == ACT_IGNORE && out_en_o) |=> out_en_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("output dropped in ignore mode");
  property p_hold;
    fault_i[*4] ##0 resp_r[7:6] == ACT_HOLD |=> !out_en_o;
  endproperty
  a_hold: assert property (p_hold) else $error("output on during held fault");
  property p_no_retry;
    $fell(out_en_o) && resp_r[7:6] == ACT_SHUT && resp_r[5:3] == RETRY_NONE && ctrl_pin_i && bias_ok_i
      |=> (!out_en_o)[*8];
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart with zero retries");
  property p_spacing;
    $rose(out_en_o) && att_r |-> low_r + 8 >= dly && low_r <= dly + 8;
  endproperty
  a_spacing: assert property (p_spacing) else $error("attempt spacing wrong");
  c_spacing: cover property ($rose(out_en_o) && att_r);
  c_hold: cover property (resp_r[7:6] == ACT_HOLD && fault_i && !out_en_o);
  c_ignore: cover property (resp_r[7:6] == ACT_IGNORE && fault_i && out_en_o);
endmodule : frr_chk
bind frr_top frr_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .fault_i(fault_i), .ctrl_pin_i(ctrl_pin_i), .bias_ok_i(bias_ok_i), .out_en_o(out_en_o), .irq_o(irq_o));

/* File: testbench/frr_load_model.sv */
`timescale 1ns/1ns
module frr_load_model (
  input wire logic out_en_i,
  input wire logic short_i,
  input wire logic ext_fault_i,
  output logic fault_o
);
  // A shorted load trips only while powered, so every restart faults again
  assign fault_o = ext_fault_i || (short_i && out_en_i);
endmodule : frr_load_model

/* File: testbench/fault_restart_retry_control_bench.sv */
`timescale 1ns/1ns
module fault_restart_retry_control_bench;
  import frr_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, pin = 1'h1, bias = 1'h1, short = 1'h0, ext = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic ack, fault, out_en, irq;
  logic [2:0] tries [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  int err_total = 0, total_checks = 0, rises = 0, gap = 0;
  time t_fall = 0;
  initial forever #4 clk_i = ~clk_i;
  always @(negedge out_en) t_fall = $time;
  always @(posedge out_en) begin
    rises++;
    gap = int'(($time - t_fall) / 8);
  end
  frr_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fault_i(fault), .ctrl_pin_i(pin),
    .bias_ok_i(bias), .out_en_o(out_en), .irq_o(irq));
  frr_load_model load (.out_en_i(out_en), .short_i(short), .ext_fault_i(ext), .fault_o(fault));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (ack !== 1'h1) begin
      chk(32'(ack), 32'h0000_0001, "ack");
      finish_test();
    end
  endtask : wb
  // Bounded wait on irq or output enable
  task automatic wt(input logic use_irq, input logic v, input int lim);
    int n;
    n = 0;
    while ((use_irq ? irq : out_en) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if ((use_irq ? irq : out_en) !== v) begin
      chk(32'h0000_0000, 32'h0000_0001, "wait");
      finish_test();
    end
  endtask : wt
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, OFS_RESP, 32'h0000_0000);
    chk(q, {24'h00_0000, RESP_RST}, "resp reset");
    wb(1'h0, OFS_UNIT, 32'h0000_0000);
    chk(q, {16'h0000, UNIT_RST}, "unit reset");
    wb(1'h1, 8'h20, 32'hffff_ffff);
    wb(1'h0, 8'h20, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped");
    wb(1'h1, OFS_UNIT, 32'h0000_0001);
    wb(1'h1, OFS_IRQ_MASK, 32'h0000_0002);
    wt(1'h0, 1'h1, 100);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wb(1'h1, OFS_RESP, {24'h00_0000, ACT_SHUT, tries[i], 3'h0});
      rises = 0;
      short <= 1'h1;
      wt(1'h1, 1'h1, 2000);
      chk(32'(rises), 32'(tries[i]), "attempts");
      short <= 1'h0;
      wb(1'h1, OFS_IRQ_MASK, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000, "irq masked");
      wb(1'h1, OFS_IRQ_MASK, 32'h0000_0002);
      chk(32'(out_en), 32'h0000_0000, "held off");
      // Cycle through three of the ways to unlatch
      if (i % 3 == 0) wb(1'h1, OFS_STATUS, 32'h0000_0001);
      else if (i % 3 == 1) wb(1'h1, OFS_CTRL, 32'h0000_0003);
      else begin
        bias <= 1'h0;
        repeat (20) @(posedge clk_i);
        bias <= 1'h1;
      end
      wt(1'h0, 1'h1, 100);
      wb(1'h1, OFS_IRQ_STAT, 32'h0000_0007);
      chk(32'(irq), 32'h0000_0000, "irq cleared");
      wb(1'h0, OFS_STATUS, 32'h0000_0000);
      chk(32'(q[ST_REM_HI:ST_REM_LO]), 32'(tries[i]), "reload");
      $display("test retry %0d done", tries[i]);
    end
    rises = 0;
    wb(1'h1, OFS_RESP, {24'h00_0000, ACT_SHUT, RETRY_CONT, 3'h0});
    short <= 1'h1;
    repeat (1500) @(posedge clk_i);
    chk(32'(rises >= 10 && irq === 1'h0), 32'h0000_0001, "continuous");
    pin <= 1'h0;
    short <= 1'h0;
    repeat (20) @(posedge clk_i);
    chk(32'(out_en), 32'h0000_0000, "pin off");
    pin <= 1'h1;
    wt(1'h0, 1'h1, 100);
    $display("test continuous done");
    for (int c = 0; c < 8; c++) begin
      wb(1'h1, OFS_RESP, {24'h00_0000, ACT_SHUT, 3'h1, 3'(c)});
      short <= 1'h1;
      wt(1'h1, 1'h1, 20000);
      chk(32'(gap + 4 >= (TICK_CYC << c) && gap <= (TICK_CYC << c) + 6), 32'h0000_0001, "spacing");
      short <= 1'h0;
      wb(1'h1, OFS_STATUS, 32'h0000_0001);
      wt(1'h0, 1'h1, 100);
      wb(1'h1, OFS_IRQ_STAT, 32'h0000_0007);
    end
    $display("test spacing done");
    // Fault clears during the wait, so the first attempt succeeds
    wb(1'h1, OFS_RESP, {24'h00_0000, ACT_SHUT, 3'h2, 3'h0});
    short <= 1'h1;
    wt(1'h0, 1'h0, 100);
    short <= 1'h0;
    wt(1'h0, 1'h1, 200);
    repeat (200) @(posedge clk_i);
    wb(1'h0, OFS_IRQ_STAT, 32'h0000_0000);
    chk(q, 32'((1 << EV_FAULT) | (1 << EV_OK)), "success event");
    wb(1'h0, OFS_STATUS, 32'h0000_0000);
    chk(q, 32'((1 << ST_OUT_BIT) | (2 << ST_REM_LO)), "success reload");
    wb(1'h1, OFS_IRQ_MASK, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0001, "irq unmasked");
    $display("test success done");
    wb(1'h1, OFS_RESP, {24'h00_0000, ACT_IGNORE, 6'h00});
    ext <= 1'h1;
    repeat (300) @(posedge clk_i);
    chk(32'(out_en), 32'h0000_0001, "ignore");
    wb(1'h1, OFS_RESP, {24'h00_0000, ACT_HOLD, 6'h00});
    repeat (10) @(posedge clk_i);
    chk(32'(out_en), 32'h0000_0000, "hold");
    ext <= 1'h0;
    wt(1'h0, 1'h1, 20);
    wb(1'h1, OFS_RESP, {24'h00_0000, ACT_CONT, 6'h00});
    ext <= 1'h1;
    repeat (60) @(posedge clk_i);
    chk(32'(out_en), 32'h0000_0001, "continue");
    repeat (200) @(posedge clk_i);
    chk(32'(out_en), 32'h0000_0000, "continue expired");
    ext <= 1'h0;
    wb(1'h1, OFS_STATUS, 32'h0000_0001);
    wt(1'h0, 1'h1, 100);
    $display("test actions done");
    finish_test();
  end
endmodule : fault_restart_retry_control_bench
